// ==== design/cfi_ctrl.v ====
// Comparator pair control: filtering, pin routing, events, interrupts and Wishbone registers
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`include "cfi_defs.vh"
// Overview of operation
// - Each comparator has its own bias level; start-up delay follows that level.
// - Filter per comparator: off, three-sample or five-sample majority.
// - Output change accepted only when N/2+1 of last N samples agree.
// - One raw sample taken every function clock cycle.
// - Filtering delays the validated result by (N-1)/2 sampling cycles.
// - Continuous: first result after N samples, then one result every cycle.
// - Single-shot with filter completes only after the Nth sample.
// - Pin routing selects raw result or synchronised filtered result.
// - Input exchange swaps comparator inputs and inverts the digital result.
// - Three interrupt sources, each with its own condition select.
// - Pending flag sets on its condition regardless of enable.
// - Enable-set writes one to enable; enable-clear writes one to disable.
// - Request active while flag set and enabled, until cleared or disabled.
// - All requests ORed onto one interrupt line.
// - Event outputs copy comparator states and window inside state when enabled.
// - Enabled input event starts a comparison after start-up delay.
// - In window mode either event starts both comparators together.
// - Standby without keep-running powers comparator down, keeps configuration.
// - With keep-running set, enabled interrupts can wake the processor.
// - Trigger write starts single-shot only if enabled and single; reads zero.
// - Starting single-shot clears done flag; completion sets it again.
// - Event-invert bit inverts the incoming event first.
module cfi_ctrl (
	input  wire        I_SYS_CLK,    // Function and bus clock
	input  wire        I_RSTN,       // Async reset, active low
	input  wire        I_WB_CYC,     // Wishbone cycle
	input  wire        I_WB_STB,     // Wishbone strobe
	input  wire        I_WB_WE,      // Wishbone write enable
	input  wire [7:0]  I_WB_ADR,     // Wishbone byte address
	input  wire [31:0] I_WB_DAT,     // Wishbone write data
	input  wire [3:0]  I_WB_SEL,     // Wishbone byte selects
	output wire [31:0] O_WB_DAT,     // Wishbone read data
	output wire        O_WB_ACK,     // Wishbone acknowledge
	input  wire [1:0]  I_CMP_RAW,    // Raw comparator results
	output wire [1:0]  O_CMP_EN,     // Comparator power enables
	output wire [1:0]  O_CMP_SWAP,   // Input exchange to analog cores
	output wire [3:0]  O_CMP_BIAS,   // Bias level per comparator
	output wire [1:0]  O_CMP_PIN,    // Comparator pin outputs
	input  wire [1:0]  I_EVT_IN,     // Incoming start events
	output wire [1:0]  O_EVT_CMP,    // Comparator state events
	output wire        O_EVT_WIN,    // Window inside event
	input  wire        I_STANDBY,    // System in standby
	output wire        O_IRQ,        // Combined interrupt
	output wire        O_WAKE        // Wake request from standby
);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_WARM = 2'h1;
	localparam [1:0] ST_FILL = 2'h2;
	localparam [1:0] ST_RUN  = 2'h3;

	function [31:0] byte_mask;
		input [3:0] sel;
		begin
			byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		end
	endfunction

	function [31:0] merge;
		input [31:0] old;
		input [31:0] dat;
		input [31:0] msk;
		begin
			merge = (old & ~msk) | (dat & msk);
		end
	endfunction

	// Least time rounds up to whole cycles
	function [7:0] stup_cycles;
		input [1:0] bias;
		reg   [31:0] ns;
		reg   [31:0] cyc;
		begin
			ns = 32'h0000_0000;
			case (bias)
				2'h0: ns = {16'h0000, `CFI_STUP_NS_B0};
				2'h1: ns = {16'h0000, `CFI_STUP_NS_B1};
				2'h2: ns = {16'h0000, `CFI_STUP_NS_B2};
				default: ns = {16'h0000, `CFI_STUP_NS_B3};
			endcase
			cyc = (ns * {16'h0000, `CFI_CLK_MHZ} + 32'd999) / 32'd1000;
			stup_cycles = (cyc == 32'h0000_0000) ? 8'h01 : cyc[7:0];
		end
	endfunction

	function [2:0] filt_n;
		input [1:0] sel;
		begin
			case (sel)
				2'h1: filt_n = 3'h3;
				2'h2: filt_n = 3'h5;
				default: filt_n = 3'h1;
			endcase
		end
	endfunction

	reg         ctrl_en_r;
	reg         srst_r;
	reg  [15:0] evcfg_r;
	reg  [2:0]  irq_en_r;
	reg  [2:0]  pend_r;
	reg  [2:0]  win_r;
	reg  [31:0] cfg0_r;
	reg  [31:0] cfg1_r;
	reg         ack_r;
	reg  [31:0] rdat_r;
	reg  [31:0] rd_nxt;
	reg  [1:0]  wprev_r;
	reg  [1:0]  evprev_r;

	wire        req  = I_WB_CYC & I_WB_STB;
	wire        wr   = req & I_WB_WE & ack_r;
	wire [7:0]  badr = {I_WB_ADR[7:2], 2'b00};
	wire [31:0] msk  = byte_mask(I_WB_SEL);
	wire [31:0] wd   = I_WB_DAT & msk;

	wire [1:0]  st_w;
	wire [1:0]  done_w;
	wire [1:0]  cset_w;
	wire [1:0]  keep_w;
	wire [1:0]  start_req;
	reg  [1:0]  wst;
	wire        wset;

	assign O_WB_ACK = ack_r;
	assign O_WB_DAT = rdat_r;

	// Trigger bits act only on write
	wire [1:0] trig = (wr && badr == `CFI_ADR_TRIG) ? wd[1:0] : 2'b00;

	wire [1:0] ev_eff = I_EVT_IN ^ evcfg_r[`CFI_EV_INV +: 2];
	wire [1:0] ev_go  = ev_eff & ~evprev_r & evcfg_r[`CFI_EV_START +: 2];
	wire [1:0] raw_go = trig | ev_go;
	assign start_req = win_r[`CFI_WIN_EN] ? {2{|raw_go}} : raw_go;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_cmp
			wire [31:0] c      = (gi == 0) ? cfg0_r : cfg1_r;
			wire        single = c[`CFI_CFG_SINGLE];
			wire        keep   = c[`CFI_CFG_KEEP];
			wire        swap   = c[`CFI_CFG_SWAP];
			wire [1:0]  isel   = c[`CFI_CFG_ISEL +: 2];
			wire [1:0]  bias   = c[`CFI_CFG_BIAS +: 2];
			wire [1:0]  filter_length_sel   = c[`CFI_CFG_FILTER_LENGTH_SEL +: 2];
			wire [1:0]  route  = c[`CFI_CFG_ROUTE +: 2];
			wire [2:0]  nlen   = filt_n(filter_length_sel);
			wire        active = ctrl_en_r & c[`CFI_CFG_EN] & ~(I_STANDBY & ~keep);
			wire        sy;
			wire        smp;
			wire        vote;
			reg  [1:0]  fsm_r;
			reg  [7:0]  cnt_r;
			reg  [2:0]  fcnt_r;
			reg         st_r;
			reg         done_r;

			cfi_sync3 u_sync (
				.i_clk  (I_SYS_CLK),
				.i_rstn (I_RSTN),
				.i_d    (I_CMP_RAW[gi]),
				.o_q    (sy)
			);

			assign smp = sy ^ swap;

			cfi_vote u_vote (
				.i_clk  (I_SYS_CLK),
				.i_rstn (I_RSTN),
				.i_clr  (fsm_r == ST_WARM),
				.i_en   (fsm_r == ST_FILL || fsm_r == ST_RUN),
				.i_smp  (smp),
				.i_len  (filter_length_sel),
				.o_vote (vote)
			);

			wire upd    = (fsm_r == ST_FILL && fcnt_r == nlen - 3'h1) || fsm_r == ST_RUN;
			wire go     = active & single & start_req[gi] & (fsm_r == ST_IDLE);
			wire kick   = go | (active & ~single & fsm_r == ST_IDLE);

			always @(posedge I_SYS_CLK or negedge I_RSTN) begin
				if (!I_RSTN) begin
					fsm_r  <= ST_IDLE;
					cnt_r  <= 8'h00;
					fcnt_r <= 3'h0;
					st_r   <= 1'b0;
					done_r <= 1'b0;
				end else if (srst_r) begin
					fsm_r  <= ST_IDLE;
					cnt_r  <= 8'h00;
					fcnt_r <= 3'h0;
					st_r   <= 1'b0;
					done_r <= 1'b0;
				end else begin
					case (fsm_r)
						ST_IDLE: begin
							if (kick) begin
								fsm_r <= ST_WARM;
								cnt_r <= stup_cycles(bias);
							end
						end
						ST_WARM: begin
							fcnt_r <= 3'h0;
							if (cnt_r <= 8'h01) begin
								fsm_r <= ST_FILL;
							end else begin
								cnt_r <= cnt_r - 8'h01;
							end
						end
						ST_FILL: begin
							fcnt_r <= fcnt_r + 3'h1;
							if (upd) begin
								fsm_r <= single ? ST_IDLE : ST_RUN;
							end
						end
						ST_RUN: begin
							if (single) begin
								fsm_r <= ST_IDLE;
							end
						end
						default: fsm_r <= ST_IDLE;
					endcase
					if (!active) begin
						fsm_r <= ST_IDLE;
					end
					if (upd) begin
						st_r <= vote;
					end
					done_r <= (active & upd) | (done_r & ~go & active);
				end
			end

			reg hit;
			always @* begin
				case (isel)
					2'h0: hit = vote ^ st_r;
					2'h1: hit = vote & ~st_r;
					2'h2: hit = ~vote & st_r;
					default: hit = single & (fsm_r == ST_FILL);
				endcase
			end

			assign cset_w[gi]            = active & upd & hit;
			assign st_w[gi]              = st_r;
			assign done_w[gi]            = done_r;
			assign keep_w[gi]            = keep;
			assign O_CMP_EN[gi]          = (fsm_r != ST_IDLE);
			assign O_CMP_SWAP[gi]        = swap;
			assign O_CMP_BIAS[2*gi +: 2] = bias;
			assign O_CMP_PIN[gi] = (route == `CFI_ROUTE_RAW)  ? (I_CMP_RAW[gi] ^ swap) :
			                       (route == `CFI_ROUTE_SYNC) ? st_r : 1'b0;
		end
	endgenerate

	always @* begin
		if (st_w[0] & st_w[1]) begin
			wst = `CFI_WST_ABOVE;
		end else if (st_w[0] ^ st_w[1]) begin
			wst = `CFI_WST_INSIDE;
		end else begin
			wst = `CFI_WST_BELOW;
		end
	end

	wire [1:0] wcond = win_r[`CFI_WIN_ISEL +: 2];
	assign wset = win_r[`CFI_WIN_EN] & (wst != wprev_r) &
	              ((wcond == `CFI_WCOND_OUTSIDE) ? (wprev_r == `CFI_WST_INSIDE) : (wst == wcond));

	assign O_EVT_CMP = st_w & evcfg_r[`CFI_EV_OUT +: 2];
	assign O_EVT_WIN = (wst == `CFI_WST_INSIDE) & evcfg_r[`CFI_EV_WOUT];

	assign O_IRQ  = |(pend_r & irq_en_r);
	assign O_WAKE = O_IRQ & (|keep_w);

	always @* begin
		case (badr)
			`CFI_ADR_CTRL:    rd_nxt = {30'h0000_0000, srst_r, ctrl_en_r};
			`CFI_ADR_EVCFG:   rd_nxt = {16'h0000, evcfg_r};
			`CFI_ADR_IRQ_CLR: rd_nxt = {29'h0000_0000, irq_en_r};
			`CFI_ADR_IRQ_SET: rd_nxt = {29'h0000_0000, irq_en_r};
			`CFI_ADR_PEND:    rd_nxt = {29'h0000_0000, pend_r};
			`CFI_ADR_STATUS:  rd_nxt = {22'h00_0000, done_w, 2'b00, wst, 2'b00, st_w};
			`CFI_ADR_WIN:     rd_nxt = {29'h0000_0000, win_r};
			`CFI_ADR_CFG0:    rd_nxt = cfg0_r;
			`CFI_ADR_CFG1:    rd_nxt = cfg1_r;
			default:          rd_nxt = `CFI_RST_WORD;
		endcase
	end

	// Ack one cycle after request; write lands on the acked edge
	always @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ack_r  <= 1'b0;
			rdat_r <= `CFI_RST_WORD;
		end else begin
			ack_r <= req & ~ack_r;
			if (req & ~ack_r) begin
				rdat_r <= rd_nxt;
			end
		end
	end

	always @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ctrl_en_r <= 1'b0;
			srst_r    <= 1'b0;
			evcfg_r   <= `CFI_RST_EVCFG;
			irq_en_r  <= 3'h0;
			pend_r    <= 3'h0;
			win_r     <= 3'h0;
			cfg0_r    <= `CFI_RST_WORD;
			cfg1_r    <= `CFI_RST_WORD;
			wprev_r   <= `CFI_WST_BELOW;
			evprev_r  <= 2'b00;
		end else if (srst_r) begin
			ctrl_en_r <= 1'b0;
			srst_r    <= 1'b0;
			evcfg_r   <= `CFI_RST_EVCFG;
			irq_en_r  <= 3'h0;
			pend_r    <= 3'h0;
			win_r     <= 3'h0;
			cfg0_r    <= `CFI_RST_WORD;
			cfg1_r    <= `CFI_RST_WORD;
			wprev_r   <= `CFI_WST_BELOW;
			evprev_r  <= 2'b00;
		end else begin
			wprev_r  <= wst;
			evprev_r <= ev_eff;
			// Flags set regardless of enable; set beats clear
			pend_r <= (pend_r & ~((wr && badr == `CFI_ADR_PEND) ? wd[2:0] : 3'h0)) | {wset, cset_w};
			if (wr) begin
				case (badr)
					`CFI_ADR_CTRL: begin
						// Reset write discards the rest of the word
						if (wd[`CFI_CTRL_SRST]) begin
							srst_r <= 1'b1;
						end else if (msk[`CFI_CTRL_EN]) begin
							ctrl_en_r <= wd[`CFI_CTRL_EN];
						end
					end
					`CFI_ADR_EVCFG: evcfg_r <= ((evcfg_r & ~msk[15:0]) | wd[15:0]) & 16'h3313;
					`CFI_ADR_IRQ_SET: irq_en_r <= irq_en_r | wd[2:0];
					`CFI_ADR_IRQ_CLR: irq_en_r <= irq_en_r & ~wd[2:0];
					`CFI_ADR_WIN:  win_r  <= (win_r & ~msk[2:0]) | wd[2:0];
					`CFI_ADR_CFG0: cfg0_r <= merge(cfg0_r, wd, msk);
					`CFI_ADR_CFG1: cfg1_r <= merge(cfg1_r, wd, msk);
					default: ctrl_en_r <= ctrl_en_r;
				endcase
			end
		end
	end

endmodule

// ==== design/cfi_defs.vh ====
// Register offsets, field positions, reset values and timing for the comparator control block
`ifndef CFI_DEFS_VH
`define CFI_DEFS_VH

// Register byte offsets on the Wishbone bus
`define CFI_ADR_CTRL      8'h00
`define CFI_ADR_TRIG      8'h04
`define CFI_ADR_EVCFG     8'h08
`define CFI_ADR_IRQ_CLR   8'h0C
`define CFI_ADR_IRQ_SET   8'h10
`define CFI_ADR_PEND      8'h14
`define CFI_ADR_STATUS    8'h18
`define CFI_ADR_WIN       8'h1C
`define CFI_ADR_CFG0      8'h20
`define CFI_ADR_CFG1      8'h24

// Control register bits
`define CFI_CTRL_EN       0
`define CFI_CTRL_SRST     1

// Comparator config register fields
`define CFI_CFG_EN        0
`define CFI_CFG_SINGLE    1
`define CFI_CFG_ISEL      2
`define CFI_CFG_KEEP      6
`define CFI_CFG_SWAP      15
`define CFI_CFG_BIAS      16
`define CFI_CFG_FILTER_LENGTH_SEL      24
`define CFI_CFG_ROUTE     28

// Event config fields
`define CFI_EV_OUT        0
`define CFI_EV_WOUT       4
`define CFI_EV_START      8
`define CFI_EV_INV        12

// Window setup fields
`define CFI_WIN_EN        0
`define CFI_WIN_ISEL      1

// Reset values
`define CFI_RST_WORD      32'h0000_0000
`define CFI_RST_EVCFG     16'h0000

// Window states and pin routing codes
`define CFI_WST_ABOVE     2'h0
`define CFI_WST_INSIDE    2'h1
`define CFI_WST_BELOW     2'h2
`define CFI_WCOND_OUTSIDE 2'h3
`define CFI_ROUTE_RAW     2'h1
`define CFI_ROUTE_SYNC    2'h2

// Start-up time per bias level in ns, and function clock rate in MHz
`define CFI_STUP_NS_B0    16'h0FA0
`define CFI_STUP_NS_B1    16'h07D0
`define CFI_STUP_NS_B2    16'h03E8
`define CFI_STUP_NS_B3    16'h01F4
`define CFI_CLK_MHZ       16'h0019

`endif

// ==== design/cfi_sync3.v ====
// Three-stage synchroniser for an asynchronous comparator output
module cfi_sync3 (
	input  wire i_clk,   // Function clock
	input  wire i_rstn,  // Async reset, active low
	input  wire i_d,     // Asynchronous input
	output reg  o_q      // Synchronised level
);

	reg s1_r;
	reg s2_r;
	reg s3_r;

	// Output moves only once stages two and three agree
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			o_q  <= 1'b0;
		end else begin
			s1_r <= i_d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				o_q <= s3_r;
			end
		end
	end

endmodule

// ==== design/cfi_vote.v ====
// Majority-vote filter over the last one, three or five comparator samples
module cfi_vote (
	input  wire       i_clk,   // Function clock
	input  wire       i_rstn,  // Async reset, active low
	input  wire       i_clr,   // Drop history at comparison start
	input  wire       i_en,    // Take a sample this cycle
	input  wire       i_smp,   // Current sample
	input  wire [1:0] i_len,   // Filter length select
	output reg        o_vote   // Majority of current plus past samples
);

	reg  [3:0] hist_r;
	wire [4:0] win = {hist_r, i_smp};
	reg  [2:0] ones;

	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			hist_r <= 4'h0;
		end else if (i_clr) begin
			hist_r <= 4'h0;
		end else if (i_en) begin
			hist_r <= {hist_r[2:0], i_smp};
		end
	end

	always @* begin
		ones = {2'b00, win[0]} + {2'b00, win[1]} + {2'b00, win[2]};
		// Off, three or five by select
		case (i_len)
			2'h1: o_vote = (ones >= 3'd2);
			2'h2: o_vote = (ones + {2'b00, win[3]} + {2'b00, win[4]} >= 3'd3);
			default: o_vote = i_smp;
		endcase
	end

endmodule

// ==== tb/cfi_ctrl_chk.sv ====
// Port-level assertions for the comparator control block
module cfi_ctrl_chk (
	input wire logic        I_SYS_CLK,  // Clock
	input wire logic        I_RSTN,     // Reset, active low
	input wire logic        I_WB_CYC,   // Bus cycle
	input wire logic        I_WB_STB,   // Bus strobe
	input wire logic        I_WB_WE,    // Bus write
	input wire logic [7:0]  I_WB_ADR,   // Bus address
	input wire logic [31:0] O_WB_DAT,   // Read data
	input wire logic        O_WB_ACK,   // Acknowledge
	input wire logic [1:0]  O_CMP_SWAP, // Input exchange
	input wire logic [3:0]  O_CMP_BIAS, // Bias levels
	input wire logic        O_IRQ,      // Interrupt
	input wire logic        O_WAKE      // Wake request
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (!I_RSTN);
	wire wr = O_WB_ACK && I_WB_WE;
	wire rd = O_WB_ACK && !I_WB_WE;
	sequence s_req;
		I_WB_CYC && I_WB_STB && !O_WB_ACK;
	endsequence
	sequence s_ack;
		O_WB_ACK ##1 !O_WB_ACK;
	endsequence
	chk_ack_next_cycle: assert property (s_req |=> s_ack)
		else $error("ack not one cycle after request");
	chk_ack_needs_req: assert property ($rose(O_WB_ACK) |-> $past(I_WB_CYC && I_WB_STB))
		else $error("ack without request");
	chk_trig_reads_zero: assert property (rd && I_WB_ADR[7:2] == 6'h01 |-> O_WB_DAT == 32'h0000_0000)
		else $error("trigger register read not zero");
	chk_unmapped_zero: assert property (rd && I_WB_ADR[7:2] > 6'h09 |-> O_WB_DAT == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_wake_needs_irq: assert property (O_WAKE |-> O_IRQ)
		else $error("wake without interrupt");
	chk_irq_hold: assert property ($fell(O_IRQ) |-> $past(wr) || $past(wr, 2))
		else $error("interrupt dropped without clear");
	chk_swap_by_write: assert property ($changed(O_CMP_SWAP) |-> $past(wr) || $past(wr, 2))
		else $error("exchange changed without write");
	chk_bias_by_write: assert property ($changed(O_CMP_BIAS) |-> $past(wr) || $past(wr, 2))
		else $error("bias changed without write");
endmodule

bind cfi_ctrl cfi_ctrl_chk chk_u (.I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_WB_CYC(I_WB_CYC),
	.I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
	.O_CMP_SWAP(O_CMP_SWAP), .O_CMP_BIAS(O_CMP_BIAS), .O_IRQ(O_IRQ), .O_WAKE(O_WAKE));

// ==== tb/cfi_cmp_model.sv ====
// Behavioural analog comparator cores facing the control block
module cfi_cmp_model (
	input  wire logic       i_clk,   // System clock
	input  wire logic [1:0] i_en,    // Core power enables
	input  wire logic [1:0] i_swap,  // Input exchange
	input  wire logic [1:0] i_lvl,   // Plus input above minus input
	output logic      [1:0] o_raw    // Analog result
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] junk_r = 2'h0;
	always @(posedge i_clk) junk_r <= ~junk_r;
	// exchanged terminals flip the result
	// Unpowered core output wanders, never holds a level
	assign o_raw = ((i_lvl ^ i_swap) & i_en) | (junk_r & ~i_en);
endmodule

// ==== tb/cfi_ctrl_tb_top.sv ====
// Self-checking bench for the comparator control block
`include "cfi_defs.vh"
module cfi_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, stby = 0, ack, irq, wake, evw;
	logic [7:0]  adr = 0;
	logic [31:0] wdat = 0, rdat, dat;
	logic [1:0]  raw, en, swap, pin, evc, evin = 0, lvl = 0;
	logic [3:0]  bias;
	int          fail_count = 0, compares = 0, n_on = 0, b, fl, sw, kp, iv, k, n0, d0;
	always #20 clk = ~clk;
	always @(posedge clk) if (en[0] === 1'b1) n_on <= n_on + 1;
	cfi_cmp_model mdl_u (.i_clk(clk), .i_en(en), .i_swap(swap), .i_lvl(lvl), .o_raw(raw));
	cfi_ctrl dut_u (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
		.I_WB_DAT(wdat), .I_WB_SEL(4'hF), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_CMP_RAW(raw), .O_CMP_EN(en),
		.O_CMP_SWAP(swap), .O_CMP_BIAS(bias), .O_CMP_PIN(pin), .I_EVT_IN(evin), .O_EVT_CMP(evc),
		.O_EVT_WIN(evw), .I_STANDBY(stby), .O_IRQ(irq), .O_WAKE(wake));
	task automatic end_of_test;
		if (fail_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
		int j;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= v;
		@(posedge clk);
		for (j = 0; j < 20 && ack !== 1'b1; j++) @(posedge clk);
		dat = rdat;
		chk(ack, 1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask
	task automatic setc(input logic [7:0] a, input logic [31:0] v);
		// exchange altered only with the core off
		wb(1, a, 0);
		wb(1, a, v & ~32'h0000_0001);
		wb(1, a, v);
	endtask
	task automatic wait_idle;
		for (k = 0; k < 400 && en !== 2'h0; k++) @(posedge clk);
	endtask
	function automatic logic [31:0] cfg(input int e, s, c, p, w, bs, f, r);
		return e << `CFI_CFG_EN | s << `CFI_CFG_SINGLE | c << `CFI_CFG_ISEL | p << `CFI_CFG_KEEP
			| w << `CFI_CFG_SWAP | bs << `CFI_CFG_BIAS | f << `CFI_CFG_FILTER_LENGTH_SEL | r << `CFI_CFG_ROUTE;
	endfunction
	function automatic int nlen(input int f);
		return f == 2 ? 5 : f == 1 ? 3 : 1;
	endfunction
	function automatic int stup(input int bs);
		int ns;
		ns = bs == 0 ? `CFI_STUP_NS_B0 : bs == 1 ? `CFI_STUP_NS_B1 : bs == 2 ? `CFI_STUP_NS_B2 : `CFI_STUP_NS_B3;
		return (ns * `CFI_CLK_MHZ + 999) / 1000;
	endfunction
	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		end_of_test();
	end
	initial begin
		void'($urandom(30));
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		wb(1, `CFI_ADR_CTRL, 1);
		for (b = 0; b < 4; b++) begin
			fl = $urandom_range(2);
			sw = $urandom_range(1);
			kp = $urandom_range(1);
			lvl <= 2'($urandom_range(3));
			setc(`CFI_ADR_CFG0, cfg(1, 1, 3, kp, sw, b, fl, 2));
			chk(bias[1:0], b);
			n0 = n_on;
			wb(1, `CFI_ADR_TRIG, 1);
			wb(0, `CFI_ADR_STATUS, 0);
			chk(dat[8], 0);
			wait_idle();
			chk(n_on - n0, stup(b) + nlen(fl));
			wb(0, `CFI_ADR_STATUS, 0);
			chk({dat[8], dat[0]}, {1'b1, lvl[0]});
			chk(pin[0], lvl[0]);
		end
		wb(0, `CFI_ADR_PEND, 0);
		chk(dat[0], 1);
		chk(irq, 0);
		wb(1, `CFI_ADR_IRQ_SET, 1);
		chk({irq, wake}, {1'b1, kp[0]});
		wb(1, `CFI_ADR_IRQ_CLR, 0);
		chk(irq, 1);
		wb(1, `CFI_ADR_IRQ_CLR, 1);
		chk(irq, 0);
		wb(1, `CFI_ADR_IRQ_SET, 1);
		wb(1, `CFI_ADR_PEND, 1);
		chk(irq, 0);
		setc(`CFI_ADR_CFG0, cfg(0, 1, 0, 0, 0, 3, 0, 0));
		wb(1, `CFI_ADR_TRIG, 1);
		chk(en, 0);
		// continuous filtering, one pass per filter length, checked outside standby
		for (fl = 0; fl < 3; fl++) begin
			lvl <= 2'h0;
			setc(`CFI_ADR_CFG0, cfg(1, 0, 1, 0, 0, 3, fl, 2));
			// Covers start-up and filter fill
			repeat (40) @(posedge clk);
			wb(1, `CFI_ADR_PEND, 7);
			lvl <= 2'h1;
			for (k = 0; k < 50 && pin[0] !== 1'b1; k++) @(posedge clk);
			// Three sync flops, agreement flop, state flop
			d0 = 6;
			chk(k, d0 + nlen(fl) / 2);
			wb(0, `CFI_ADR_PEND, 0);
			chk(dat[0], 1);
			wb(1, `CFI_ADR_PEND, 1);
			lvl <= 2'h0;
			repeat (20) @(posedge clk);
			wb(0, `CFI_ADR_PEND, 0);
			chk(dat[0], 0);
		end
		iv = $urandom_range(1);
		lvl <= 2'h2;
		evin <= {iv[0], 1'b0};
		wb(1, `CFI_ADR_WIN, 1 | `CFI_WST_INSIDE << `CFI_WIN_ISEL);
		setc(`CFI_ADR_CFG0, cfg(1, 1, 0, 0, 0, 3, 1, 2));
		setc(`CFI_ADR_CFG1, cfg(1, 1, 0, 0, 0, 3, 1, 2));
		wb(1, `CFI_ADR_EVCFG, 2 << `CFI_EV_START | iv << `CFI_EV_INV + 1);
		chk(en, 0);
		evin[1] <= ~iv[0];
		repeat (3) @(posedge clk);
		chk(en, 3);
		wait_idle();
		wb(1, `CFI_ADR_EVCFG, 2 << `CFI_EV_START | iv << `CFI_EV_INV + 1 | 3 << `CFI_EV_OUT | 1 << `CFI_EV_WOUT);
		chk({evw, evc}, {1'b1, lvl});
		wb(0, `CFI_ADR_STATUS, 0);
		chk(dat[5:4], `CFI_WST_INSIDE);
		wb(0, `CFI_ADR_PEND, 0);
		chk(dat[2], 1);
		// window off, so each core may keep its own setting
		wb(1, `CFI_ADR_WIN, 0);
		for (kp = 0; kp < 2; kp++) begin
			sw = $urandom_range(1);
			lvl <= 2'($urandom_range(3));
			setc(`CFI_ADR_CFG0, cfg(1, 0, 0, kp, sw, 3, 0, 1));
			chk(pin[0], lvl[0]);
			chk(swap[0], sw[0]);
			stby <= 1'b1;
			repeat (3) @(posedge clk);
			chk(en[0], kp);
			stby <= 1'b0;
			wb(0, `CFI_ADR_CFG0, 0);
			chk(dat, cfg(1, 0, 0, kp, sw, 3, 0, 1));
			chk(en[0], 1);
		end
		wb(0, 8'h40, 0);
		chk(dat, 0);
		wb(0, `CFI_ADR_TRIG, 0);
		chk(dat, 0);
		wb(1, `CFI_ADR_CTRL, 2);
		repeat (2) @(posedge clk);
		wb(0, `CFI_ADR_CFG0, 0);
		chk(dat, `CFI_RST_WORD);
		end_of_test();
	end
endmodule
